// ==== hw/ddhp_defines.svh ====
// Purpose: Shared constants for the display driver host port
// Assumes: Included by bare name
// Notes: Command codes, field positions, reset values and counts
`ifndef DDHP_DEFINES_SVH
`define DDHP_DEFINES_SVH
`define DDHP_DATA_W 18
`define DDHP_FIFO_DEPTH 32
`define DDHP_SER_BITS 4'h8
`define DDHP_CMD_REMAP_FORMAT 8'hA0
`define DDHP_CMD_CONTRAST 8'hC1
`define DDHP_CMD_MASTER_CURRENT 8'hC7
`define DDHP_CMD_DISPLAY_OFF 8'hAE
`define DDHP_CMD_DISPLAY_ON 8'hAF
`define DDHP_REMAP_WIDTH_BIT 3
`define DDHP_CONTRAST_RST 8'h80
`define DDHP_MASTER_RST 4'hF
`endif

// ==== hw/ddhp_pkg.sv ====
// Purpose: Types for the display driver host port
// Assumes: Nothing
// Notes: Bus modes chosen by straps
package ddhp_pkg;
    typedef enum logic [1:0] {
        DDHP_BUS_SERIAL,
        DDHP_BUS_MOTO,
        DDHP_BUS_INTEL
    } ddhp_bus_e;
    typedef logic [17:0] ddhp_word_t;
endpackage

// ==== hw/ddhp_fifo.sv ====
// Purpose: Pixel data FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active high reset
// Notes: Read data comes from a register
`timescale 1ns/10ps
module ddhp_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr;
    logic [AW-1:0] rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic vld_ff, nxt_vld;
    logic rdy_ff, nxt_rdy;
    logic [WIDTH-1:0] dat_ff, nxt_dat;
    logic push, pop, load;

    always_comb begin
        push = i_in_valid && rdy_ff;
        load = (cnt_ff != '0) && (!vld_ff || i_out_ready);
        pop = load;
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_rdy = (nxt_cnt != (AW+1)'(DEPTH));
        nxt_vld = load ? 1'b1 : (i_out_ready ? 1'b0 : vld_ff);
        nxt_dat = load ? mem[rd_ff] : dat_ff;
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ff] <= i_in_data;
        end
        if (i_rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            vld_ff <= 1'b0;
            rdy_ff <= 1'b1;
            dat_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            vld_ff <= nxt_vld;
            rdy_ff <= nxt_rdy;
            dat_ff <= nxt_dat;
        end
    end

    assign o_in_ready = rdy_ff;
    assign o_out_valid = vld_ff;
    assign o_out_data = dat_ff;
endmodule

// ==== hw/ddhp_serial.sv ====
// Purpose: Serial byte assembler for the host port
// Assumes: Inputs already synchronised to i_clk
// Notes: Emits one byte pulse on every eighth rising serial clock
`timescale 1ns/10ps
`include "ddhp_defines.svh"
module ddhp_serial (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Synchronised serial lines
    input wire logic i_en,
    input wire logic i_sclk,
    input wire logic i_serial_data_in,
    input wire logic i_dc,
    // Assembled byte
    output logic o_byte_vld,
    output logic [7:0] o_byte,
    output logic o_byte_dc
);
    logic sclk_d_ff, nxt_sclk_d;
    logic [7:0] sh_ff, nxt_sh;
    logic [3:0] cnt_ff, nxt_cnt;
    logic vld_ff, nxt_vld;
    logic [7:0] byte_ff, nxt_byte;
    logic dc_ff, nxt_dc;
    logic rise;

    always_comb begin
        rise = i_sclk && !sclk_d_ff;
        nxt_sclk_d = i_sclk;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_vld = 1'b0;
        nxt_byte = byte_ff;
        nxt_dc = dc_ff;
        if (!i_en) begin
            nxt_cnt = 4'h0;
        end else if (rise) begin
            nxt_sh = {sh_ff[6:0], i_serial_data_in};
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff + 4'h1 == `DDHP_SER_BITS) begin
                nxt_cnt = 4'h0;
                nxt_vld = 1'b1;
                nxt_byte = {sh_ff[6:0], i_serial_data_in};
                nxt_dc = i_dc;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_d_ff <= 1'b0;
            sh_ff <= 8'h00;
            cnt_ff <= 4'h0;
            vld_ff <= 1'b0;
            byte_ff <= 8'h00;
            dc_ff <= 1'b0;
        end else begin
            sclk_d_ff <= nxt_sclk_d;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            vld_ff <= nxt_vld;
            byte_ff <= nxt_byte;
            dc_ff <= nxt_dc;
        end
    end

    assign o_byte_vld = vld_ff;
    assign o_byte = byte_ff;
    assign o_byte_dc = dc_ff;
endmodule

// ==== hw/ddhp_top.sv ====
// Purpose: Host port of a colour dot-matrix display driver
// Assumes: All pins asynchronous to i_clk; 125 MHz clock
// Notes: Pixel words enter a FIFO; commands go to o_cmd_*
`timescale 1ns/10ps
`include "ddhp_defines.svh"
module ddhp_top
    import ddhp_pkg::*;
#(
    parameter int DATA_W = `DDHP_DATA_W,
    parameter int FIFO_DEPTH = `DDHP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reset_n_pin,
    // Straps
    input wire logic i_bus_width_strap,
    input wire logic i_bus_style_strap,
    input wire logic i_parallel_serial_strap,
    input wire logic i_osc_source_strap,
    // Host bus controls
    input wire logic i_cs_n,
    input wire logic i_dc,
    input wire logic i_en_rd_n,
    input wire logic i_rw_wr_n,
    // Data bus pins
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data,
    output logic [DATA_W-1:0] o_data_oe,
    // Read-back word from display memory
    input wire ddhp_pkg::ddhp_word_t i_rd_word,
    // Pixel stream toward display memory
    output logic o_pix_valid,
    output ddhp_pkg::ddhp_word_t o_pix_data,
    input wire logic i_pix_ready,
    output logic o_fifo_ready,
    // Command stream
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_byte,
    output logic o_cmd_is_data,
    // Status
    output ddhp_pkg::ddhp_bus_e o_bus_mode,
    output logic o_bus_width_soft_bit,
    output logic o_use_int_osc,
    output logic o_drivers_hiz,
    output logic [7:0] o_contrast_a,
    output logic [7:0] o_contrast_b,
    output logic [7:0] o_contrast_c,
    output logic [3:0] o_master_current,
    output logic [4:0] o_scale_factor
);
    import ddhp_pkg::*;

    localparam int NS = 8;
    logic [NS-1:0] s1_ff, s2_ff;
    logic [DATA_W-1:0] d1_ff, d2_ff;
    logic rst_all;
    logic sync_rst_n, cs_n, dc, strb, rw;
    logic strap_w, strap_s, strap_p, strap_o;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_ff <= '1;
            s2_ff <= '1;
            d1_ff <= '0;
            d2_ff <= '0;
        end else begin
            s1_ff <= {i_reset_n_pin, i_cs_n, i_dc, i_en_rd_n, i_rw_wr_n,
                      i_bus_width_strap, i_bus_style_strap,
                      i_parallel_serial_strap ^ i_osc_source_strap ^ 1'b0};
            s2_ff <= s1_ff;
            d1_ff <= i_data;
            d2_ff <= d1_ff;
        end
    end

    // Parallel/serial and oscillator strap bits separately synchronised
    logic [1:0] ps1_ff, ps2_ff;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ps1_ff <= 2'b11;
            ps2_ff <= 2'b11;
        end else begin
            ps1_ff <= {i_parallel_serial_strap, i_osc_source_strap};
            ps2_ff <= ps1_ff;
        end
    end

    always_comb begin
        sync_rst_n = s2_ff[7];
        cs_n = s2_ff[6];
        dc = s2_ff[5];
        strb = s2_ff[4];
        rw = s2_ff[3];
        strap_w = s2_ff[2];
        strap_s = s2_ff[1];
        strap_p = ps2_ff[1];
        strap_o = ps2_ff[0];
        rst_all = i_rst || !sync_rst_n;
    end

    // Bus state
    logic stb_d_ff, nxt_stb_d;
    logic rw_d_ff, nxt_rw_d;
    logic pvld_ff, nxt_pvld;
    ddhp_word_t pword_ff, nxt_pword;
    logic cvld_ff, nxt_cvld;
    logic [7:0] cbyte_ff, nxt_cbyte;
    logic cdat_ff, nxt_cdat;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic [DATA_W-1:0] doe_ff, nxt_doe;
    ddhp_word_t rdpipe_ff, nxt_rdpipe;
    ddhp_bus_e mode_ff, nxt_mode;
    logic soft_ff, nxt_soft;
    logic osc_ff, nxt_osc;
    logic off_ff, nxt_off;
    logic [7:0] con_ff [3];
    logic [7:0] nxt_con [3];
    logic [3:0] mst_ff, nxt_mst;
    logic [1:0] arg_ff, nxt_arg;
    logic [7:0] op_ff, nxt_op;
    logic [DATA_W-1:0] wmask;
    logic active, wr_go, rd_go, rd_end;
    logic ser_vld, ser_dc, fifo_rdy;
    logic [7:0] ser_byte;
    logic cmd_go, cmd_dc;
    logic [7:0] cmd_b;

    always_comb begin
        nxt_stb_d = strb;
        nxt_mode = mode_ff;
        if (!strap_p) begin
            nxt_mode = DDHP_BUS_SERIAL;
        end else if (strap_s) begin
            nxt_mode = DDHP_BUS_INTEL;
        end else begin
            nxt_mode = DDHP_BUS_MOTO;
        end
        nxt_osc = strap_o;
        // width mask from bus width strap and soft bit
        case ({strap_w, soft_ff})
            2'b00: wmask = 18'h0_00FF;
            2'b01: wmask = 18'h0_01FF;
            2'b10: wmask = 18'h0_FFFF;
            default: wmask = 18'h3_FFFF;
        endcase
        active = !cs_n;
        wr_go = 1'b0;
        rd_go = 1'b0;
        rd_end = 1'b0;
        case (mode_ff)
            DDHP_BUS_MOTO: begin
                rd_go = active && strb && !stb_d_ff && rw;
                rd_end = !strb && stb_d_ff;
                wr_go = active && !strb && stb_d_ff && !rw;
            end
            DDHP_BUS_INTEL: begin
                rd_go = active && !strb && stb_d_ff;
                rd_end = strb;
                // write latched on rising write strobe
                wr_go = active && rw && !rw_d_ff;
            end
            default: begin
                wr_go = 1'b0;
            end
        endcase
    end

    assign nxt_rw_d = rw;

    // line 0 clock, line 1 data
    ddhp_serial u_serial (
        .i_clk(i_clk),
        .i_rst(rst_all),
        .i_en(active && (mode_ff == DDHP_BUS_SERIAL)),
        .i_sclk(d2_ff[0]),
        .i_serial_data_in(d2_ff[1]),
        .i_dc(dc),
        .o_byte_vld(ser_vld),
        .o_byte(ser_byte),
        .o_byte_dc(ser_dc)
    );

    always_comb begin
        cmd_go = ser_vld || wr_go;
        cmd_dc = ser_vld ? ser_dc : dc;
        cmd_b = ser_vld ? ser_byte : d2_ff[7:0];
        nxt_pvld = 1'b0;
        nxt_pword = pword_ff;
        nxt_cvld = 1'b0;
        nxt_cbyte = cbyte_ff;
        nxt_cdat = cdat_ff;
        nxt_soft = soft_ff;
        nxt_off = off_ff;
        nxt_con = con_ff;
        nxt_mst = mst_ff;
        nxt_arg = arg_ff;
        nxt_op = op_ff;
        nxt_dout = dout_ff;
        nxt_doe = doe_ff;
        nxt_rdpipe = rdpipe_ff;
        if (cmd_go) begin
            nxt_cvld = 1'b1;
            nxt_cbyte = cmd_b;
            nxt_cdat = cmd_dc;
            if (cmd_dc) begin
                nxt_pvld = fifo_rdy;
                nxt_pword = ser_vld ? {10'h000, ser_byte}
                                    : (d2_ff & wmask);
            end else if (arg_ff != 2'b00) begin
                nxt_arg = arg_ff - 2'b01;
                case (op_ff)
                    `DDHP_CMD_REMAP_FORMAT: begin
                        nxt_soft = cmd_b[`DDHP_REMAP_WIDTH_BIT];
                    end
                    `DDHP_CMD_CONTRAST: begin
                        nxt_con[3 - arg_ff] = cmd_b;
                    end
                    `DDHP_CMD_MASTER_CURRENT: begin
                        nxt_mst = cmd_b[3:0];
                    end
                    default: begin
                        nxt_arg = 2'b00;
                    end
                endcase
            end else begin
                nxt_op = cmd_b;
                case (cmd_b)
                    `DDHP_CMD_REMAP_FORMAT: nxt_arg = 2'b01;
                    `DDHP_CMD_CONTRAST: nxt_arg = 2'b11;
                    `DDHP_CMD_MASTER_CURRENT: nxt_arg = 2'b01;
                    `DDHP_CMD_DISPLAY_OFF: nxt_off = 1'b1;
                    `DDHP_CMD_DISPLAY_ON: nxt_off = 1'b0;
                    default: nxt_arg = 2'b00;
                endcase
            end
        end
        if (rd_go && !cs_n) begin
            nxt_dout = rdpipe_ff & wmask;
            nxt_doe = wmask;
            nxt_rdpipe = i_rd_word;
        end else if (rd_end || cs_n) begin
            nxt_doe = '0;
        end
    end

    ddhp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(rst_all),
        .i_in_valid(pvld_ff),
        .i_in_data(pword_ff),
        .o_in_ready(fifo_rdy),
        .o_out_valid(o_pix_valid),
        .o_out_data(o_pix_data),
        .i_out_ready(i_pix_ready)
    );

    always_ff @(posedge i_clk) begin
        if (rst_all) begin
            stb_d_ff <= 1'b1;
            rw_d_ff <= 1'b1;
            pvld_ff <= 1'b0;
            pword_ff <= '0;
            cvld_ff <= 1'b0;
            cbyte_ff <= 8'h00;
            cdat_ff <= 1'b0;
            dout_ff <= '0;
            doe_ff <= '0;
            rdpipe_ff <= '0;
            mode_ff <= DDHP_BUS_SERIAL;
            soft_ff <= 1'b0;
            osc_ff <= 1'b1;
            off_ff <= 1'b1;
            con_ff <= '{`DDHP_CONTRAST_RST, `DDHP_CONTRAST_RST,
                        `DDHP_CONTRAST_RST};
            mst_ff <= `DDHP_MASTER_RST;
            arg_ff <= 2'b00;
            op_ff <= 8'h00;
        end else begin
            stb_d_ff <= nxt_stb_d;
            rw_d_ff <= nxt_rw_d;
            pvld_ff <= nxt_pvld;
            pword_ff <= nxt_pword;
            cvld_ff <= nxt_cvld;
            cbyte_ff <= nxt_cbyte;
            cdat_ff <= nxt_cdat;
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            rdpipe_ff <= nxt_rdpipe;
            mode_ff <= nxt_mode;
            soft_ff <= nxt_soft;
            osc_ff <= nxt_osc;
            off_ff <= nxt_off;
            con_ff <= nxt_con;
            mst_ff <= nxt_mst;
            arg_ff <= nxt_arg;
            op_ff <= nxt_op;
        end
    end

    // scale factor is master plus one
    logic [4:0] scale_ff;
    always_ff @(posedge i_clk) begin
        if (rst_all) begin
            scale_ff <= 5'h10;
        end else begin
            scale_ff <= {1'b0, nxt_mst} + 5'h01;
        end
    end

    assign o_data = dout_ff;
    assign o_data_oe = doe_ff;
    assign o_fifo_ready = fifo_rdy;
    assign o_cmd_valid = cvld_ff;
    assign o_cmd_byte = cbyte_ff;
    assign o_cmd_is_data = cdat_ff;
    assign o_bus_mode = mode_ff;
    assign o_bus_width_soft_bit = soft_ff;
    assign o_use_int_osc = osc_ff;
    assign o_drivers_hiz = off_ff;
    assign o_contrast_a = con_ff[0];
    assign o_contrast_b = con_ff[1];
    assign o_contrast_c = con_ff[2];
    assign o_master_current = mst_ff;
    assign o_scale_factor = scale_ff;
endmodule

// ==== tb/ddhp_host_model.sv ====
// Purpose: Host controller model for the display host port pins
// Assumes: Pins change 1 ns after the rising clock
// Notes: Released data lines show the inverse of their last value; after a serial byte line 0 stays low
`timescale 1ns/10ps
module ddhp_host_model (
    // Clock and device side of the data pins
    input wire logic i_clk,
    input wire logic [17:0] i_dev_data,
    input wire logic [17:0] i_dev_oe,
    // Host pins
    output logic o_cs_n,
    output logic o_dc,
    output logic o_en_rd_n,
    output logic o_rw_wr_n,
    output logic [17:0] o_pin_data
);
    logic [17:0] host_q;

    // Level of each shared line from both drivers
    assign o_pin_data = (i_dev_oe & i_dev_data) | (~i_dev_oe & host_q);

    initial begin
        o_cs_n = 1'b1;
        o_dc = 1'b0;
        o_en_rd_n = 1'b1;
        o_rw_wr_n = 1'b1;
        host_q = 18'h0_0000;
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic idle(input logic intel);
        o_en_rd_n = intel;
        o_rw_wr_n = 1'b1;
    endtask

    task automatic par_write(input logic intel, input logic cs,
                             input logic dc, input logic [17:0] w);
        o_cs_n = !cs;
        o_dc = dc;
        host_q = w;
        o_rw_wr_n = intel;
        step(1);
        if (intel)
            o_rw_wr_n = 1'b0;
        else
            o_en_rd_n = 1'b1;
        step(4);
        if (intel)
            o_rw_wr_n = 1'b1;
        else
            o_en_rd_n = 1'b0;
        step(4);
        o_cs_n = 1'b1;
        o_rw_wr_n = 1'b1;
        host_q = ~host_q;
        step(1);
    endtask

    task automatic par_read(input logic intel, output logic [17:0] w,
                            output logic [17:0] oe);
        o_cs_n = 1'b0;
        o_dc = 1'b1;
        step(1);
        o_en_rd_n = !intel;
        step(6);
        w = o_pin_data;
        oe = i_dev_oe;
        o_en_rd_n = intel;
        step(4);
        o_cs_n = 1'b1;
        step(1);
    endtask

    // clock on line 0, data on line 1, MSB first
    task automatic ser_byte(input logic dc, input logic [7:0] b);
        int i;
        o_cs_n = 1'b0;
        o_dc = dc;
        for (i = 7; i >= 0; i--) begin
            host_q[1] = b[i];
            host_q[0] = 1'b0;
            step(3);
            host_q[0] = 1'b1;
            step(3);
        end
        host_q[0] = 1'b0;
        step(3);
        o_cs_n = 1'b1;
        host_q[17:1] = ~host_q[17:1];
        step(1);
    endtask
endmodule

// ==== tb/ddhp_top_assertions.sv ====
// Purpose: Port checker for the display host port
// Assumes: Straps change only while a reset is applied
// Notes: Bound into ddhp_top after the module
`timescale 1ns/10ps
module ddhp_chk #(
    parameter int DATA_W = 18,
    parameter int FIFO_DEPTH = 32
) (
    // Clock, resets, straps, select, pixel ready
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reset_n_pin,
    input wire logic i_bus_width_strap,
    input wire logic i_bus_style_strap,
    input wire logic i_parallel_serial_strap,
    input wire logic i_osc_source_strap,
    input wire logic i_cs_n,
    input wire logic i_pix_ready,
    // Device outputs
    input wire logic [DATA_W-1:0] o_data_oe,
    input wire logic o_pix_valid,
    input wire logic o_fifo_ready,
    input wire logic o_cmd_valid,
    input wire logic [7:0] o_cmd_byte,
    input wire logic o_cmd_is_data,
    input wire ddhp_pkg::ddhp_bus_e o_bus_mode,
    input wire logic o_bus_width_soft_bit,
    input wire logic o_use_int_osc,
    input wire logic o_drivers_hiz,
    input wire logic [7:0] o_contrast_a,
    input wire logic [3:0] o_master_current,
    input wire logic [4:0] o_scale_factor
);
    import ddhp_pkg::*;
    logic [2:0] cs_hi_ff, nxt_cs_hi, run_ff, nxt_run;
    logic [17:0] wmask;
    ddhp_bus_e exp_mode;

    // Cycles with chip select high, and since the last reset
    always_comb begin
        nxt_cs_hi = i_cs_n ? cs_hi_ff + 3'(cs_hi_ff != 3'h7) : 3'h0;
        nxt_run = run_ff + 3'(run_ff != 3'h7);
        if (!i_reset_n_pin)
            nxt_run = 3'h0;
    end
    always_ff @(posedge i_clk) begin
        cs_hi_ff <= i_rst ? 3'h0 : nxt_cs_hi;
        run_ff <= i_rst ? 3'h0 : nxt_run;
    end
    assign wmask = i_bus_width_strap
        ? (o_bus_width_soft_bit ? 18'h3_ffff : 18'h0_ffff)
        : (o_bus_width_soft_bit ? 18'h0_01ff : 18'h0_00ff);
    assign exp_mode = !i_parallel_serial_strap ? DDHP_BUS_SERIAL
        : (i_bus_style_strap ? DDHP_BUS_INTEL : DDHP_BUS_MOTO);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    chk_cs_no_cmd: assert property (
        cs_hi_ff == 3'h7 |-> !o_cmd_valid)
        else $error("command while deselected");
    chk_cs_no_drive: assert property (
        cs_hi_ff == 3'h7 |-> o_data_oe == '0)
        else $error("bus driven while deselected");
    chk_oe_width: assert property (
        (o_data_oe & ~DATA_W'(wmask)) == '0)
        else $error("data line above width driven");
    chk_scale_master: assert property (
        $stable(o_master_current) |->
            o_scale_factor == 5'(o_master_current) + 5'h01)
        else $error("scale factor not master plus one");
    chk_cmd_pulse: assert property (
        o_cmd_valid |=> !o_cmd_valid)
        else $error("command valid longer than a cycle");
    chk_pin_reset: assert property (
        !i_reset_n_pin [*4] |=> o_drivers_hiz && o_contrast_a == 8'h80
            && o_master_current == 4'hf)
        else $error("pin reset left state");
    chk_osc_select: assert property (
        run_ff == 3'h7 |-> o_use_int_osc == i_osc_source_strap)
        else $error("oscillator choice wrong");
    chk_bus_mode: assert property (
        run_ff == 3'h7 |-> o_bus_mode == exp_mode)
        else $error("bus mode wrong");
    chk_off_hiz: assert property (
        o_cmd_valid && !o_cmd_is_data && o_cmd_byte == 8'hae
            |-> ##[0:4] o_drivers_hiz)
        else $error("drivers not off");
    chk_on_drive: assert property (
        o_cmd_valid && !o_cmd_is_data && o_cmd_byte == 8'haf
            |-> ##[0:4] !o_drivers_hiz)
        else $error("drivers not on");

    cov_pix_move: cover property (o_pix_valid && i_pix_ready);
    cov_fifo_full: cover property (!o_fifo_ready);
    cov_read: cover property (o_data_oe != '0);
endmodule

bind ddhp_top ddhp_chk #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH))
    ddhp_chk_i (.*);

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the display host port
// Assumes: Inputs change 1 ns after the rising clock
// Notes: Commands and pixels are predicted from queues; reads are checked against i_rd_word
`timescale 1ns/10ps
`include "ddhp_defines.svh"
module testbench;
    import ddhp_pkg::*;
    logic i_clk, i_rst, i_reset_n_pin, i_pix_ready;
    logic i_bus_width_strap, i_bus_style_strap;
    logic i_parallel_serial_strap, i_osc_source_strap;
    logic i_cs_n, i_dc, i_en_rd_n, i_rw_wr_n;
    logic [17:0] i_data, o_data, o_data_oe, wmask, rd, oe, e;
    ddhp_word_t i_rd_word, o_pix_data;
    logic o_pix_valid, o_fifo_ready, o_cmd_valid, o_cmd_is_data;
    logic [7:0] o_cmd_byte, o_contrast_a, o_contrast_b, o_contrast_c;
    ddhp_bus_e o_bus_mode;
    logic o_bus_width_soft_bit, o_use_int_osc, o_drivers_hiz;
    logic [3:0] o_master_current;
    logic [4:0] o_scale_factor;
    logic soft_m, exp_hiz;
    int n_fail, total_checks, seed, i, exp_mst;
    int exp_con[3];
    logic [7:0] cmd_q[$];
    logic [17:0] pix_q[$];

    ddhp_top ddhp_top_i (.*);
    ddhp_host_model ddhp_host_model_i (
        .i_clk(i_clk),
        .i_dev_data(o_data),
        .i_dev_oe(o_data_oe),
        .o_cs_n(i_cs_n),
        .o_dc(i_dc),
        .o_en_rd_n(i_en_rd_n),
        .o_rw_wr_n(i_rw_wr_n),
        .o_pin_data(i_data)
    );

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    assign wmask = i_bus_width_strap
        ? (soft_m ? 18'h3_ffff : 18'h0_ffff)
        : (soft_m ? 18'h0_01ff : 18'h0_00ff);

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [17:0] x,
                       input logic [17:0] g);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic defaults();
        exp_hiz = 1'b1;
        exp_con = '{3{`DDHP_CONTRAST_RST}};
        exp_mst = 15;
        soft_m = 1'b0;
    endtask

    task automatic chk_state();
        ddhp_bus_e m;
        m = !i_parallel_serial_strap ? DDHP_BUS_SERIAL
            : (i_bus_style_strap ? DDHP_BUS_INTEL : DDHP_BUS_MOTO);
        chk("hiz", 18'(exp_hiz), 18'(o_drivers_hiz));
        chk("contrast a", 18'(exp_con[0]), 18'(o_contrast_a));
        chk("contrast b", 18'(exp_con[1]), 18'(o_contrast_b));
        chk("contrast c", 18'(exp_con[2]), 18'(o_contrast_c));
        chk("master", 18'(exp_mst), 18'(o_master_current));
        chk("scale", 18'(exp_mst + 1), 18'(o_scale_factor));
        chk("soft", 18'(soft_m), 18'(o_bus_width_soft_bit));
        chk("osc", 18'(i_osc_source_strap), 18'(o_use_int_osc));
        chk("mode", 18'(m), 18'(o_bus_mode));
    endtask

    task automatic pin_reset(input logic [3:0] st);
        i_reset_n_pin = 1'b0;
        step(1);
        {i_bus_width_strap, i_bus_style_strap, i_parallel_serial_strap,
            i_osc_source_strap} = st;
        ddhp_host_model_i.idle(st[2]);
        step(4);
        i_reset_n_pin = 1'b1;
        defaults();
        step(8);
        chk_state();
    endtask

    task automatic send(input logic [7:0] b);
        cmd_q.push_back(b);
        if (!i_parallel_serial_strap)
            ddhp_host_model_i.ser_byte(1'b0, b);
        else
            ddhp_host_model_i.par_write(i_bus_style_strap, 1'b1, 1'b0,
                {10'($random(seed)), b});
    endtask

    task automatic wr_pix(input logic [17:0] w);
        // Memory words plus the output register
        if (pix_q.size() <= `DDHP_FIFO_DEPTH)
            pix_q.push_back(w & wmask);
        ddhp_host_model_i.par_write(i_bus_style_strap, 1'b1, 1'b1, w);
    endtask

    task automatic rd_chk(input logic intel);
        i_rd_word = 18'($random(seed));
        ddhp_host_model_i.par_read(intel, rd, oe);
        ddhp_host_model_i.par_read(intel, rd, oe);
        chk("read data", i_rd_word & wmask, rd & wmask);
        chk("read drive", wmask, oe);
    endtask

    task automatic set_master(input int m);
        exp_mst = m;
        send(`DDHP_CMD_MASTER_CURRENT);
        send(8'(m + ($random(seed) & 8'h70)));
        step(6);
        chk_state();
    endtask

    always @(negedge i_clk) begin
        if (o_cmd_valid === 1'b1 && o_cmd_is_data === 1'b0) begin
            e = cmd_q.size() ? 18'(cmd_q.pop_front()) : 'x;
            chk("command", e, 18'(o_cmd_byte));
        end
        if (o_pix_valid === 1'b1 && i_pix_ready === 1'b1) begin
            e = pix_q.size() ? pix_q.pop_front() : 'x;
            chk("pixel", e, o_pix_data);
        end
    end

    initial begin
        #(8 * 20000);
        n_fail++;
        test_done();
    end

    initial begin
        seed = 32'h3b6a;
        n_fail = 0;
        total_checks = 0;
        i_rst = 1'b1;
        i_reset_n_pin = 1'b1;
        i_pix_ready = 1'b0;
        i_rd_word = 18'h0_0000;
        {i_bus_width_strap, i_bus_style_strap, i_parallel_serial_strap,
            i_osc_source_strap} = 4'hf;
        defaults();
        step(20);
        i_rst = 1'b0;
        step(8);
        chk_state();
        send(`DDHP_CMD_DISPLAY_ON);
        exp_hiz = 1'b0;
        send(`DDHP_CMD_CONTRAST);
        for (i = 0; i < 3; i++) begin
            exp_con[i] = $random(seed) & 8'h7f;
            send(8'(exp_con[i]));
        end
        set_master(0);
        set_master(15);
        set_master($random(seed) & 15);
        send(`DDHP_CMD_REMAP_FORMAT);
        send(8'h08);
        soft_m = 1'b1;
        // Deselected writes must change nothing
        ddhp_host_model_i.par_write(1'b1, 1'b0, 1'b0, 18'h0_00c7);
        ddhp_host_model_i.par_write(1'b1, 1'b0, 1'b0, 18'h0_0005);
        step(6);
        chk_state();
        for (i = 0; i < 34; i++)
            wr_pix(18'($random(seed)));
        chk("fifo ready", 18'h0_0000, 18'(o_fifo_ready));
        for (i = 0; i < 3000 && pix_q.size() > 0; i++) begin
            i_pix_ready = 1'($random(seed));
            step(1);
        end
        i_pix_ready = 1'b1;
        step(10);
        chk("fifo left", 18'h0_0000, 18'(pix_q.size()));
        chk("fifo ready", 18'h0_0001, 18'(o_fifo_ready));
        rd_chk(1'b1);
        send(`DDHP_CMD_DISPLAY_OFF);
        exp_hiz = 1'b1;
        step(6);
        chk_state();
        pin_reset(4'h2);
        set_master(9);
        wr_pix(18'($random(seed)));
        step(10);
        chk("fifo left", 18'h0_0000, 18'(pix_q.size()));
        rd_chk(1'b0);
        pin_reset(4'h1);
        set_master(3);
        chk("commands left", 18'h0_0000, 18'(cmd_q.size()));
        test_done();
    end
endmodule
